// ### ddfe_pkg.sv
package ddfe_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int COL_W = 10;
  localparam int BA_W = 3;
  localparam int DQ_W = 8;
  localparam int NUM_BANKS = 8;
  localparam int ROW_W_DOC = 14;
  localparam int AUTO_CLOSE_BIT = 10;
  localparam int LAT_W = 5;

  // ---------------------------------------------------------------------------
  // Register map (byte offsets)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] REFCNT_OFS = 8'h08;

  // CTRL fields
  localparam int CL_LSB = 0;
  localparam int CL_W = 4;
  localparam int AL_LSB = 4;
  localparam int AL_W = 2;
  localparam int BL8_BIT = 8;
  localparam int INTLV_BIT = 9;
  localparam int CTRL_W = 10;
  localparam logic [CL_W-1:0] CL_RST = 4'h5;
  localparam logic [AL_W-1:0] AL_RST = 2'h0;
  localparam logic BL8_RST = 1'b1;
  localparam logic INTLV_RST = 1'b0;

  // Posted latency selections
  localparam logic [AL_W-1:0] AL_ZERO = 2'h0;
  localparam logic [AL_W-1:0] AL_CL_M1 = 2'h1;
  localparam logic [AL_W-1:0] AL_CL_M2 = 2'h2;

  // STATUS fields
  localparam int PWR_LSB = 0;
  localparam int OPEN_LSB = 8;
  localparam int BUSY_BIT = 16;
  localparam int STAT_W = 13;

  // ---------------------------------------------------------------------------
  // Commands {ras_n, cas_n, we_n} with chip select low
  // ---------------------------------------------------------------------------
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_REF = 3'h1;

  // Last beat index of a burst (two transfers per clock)
  localparam logic [2:0] LAST_IDX_BL8 = 3'h6;
  localparam logic [2:0] LAST_IDX_BL4 = 3'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    PW_ACTIVE = 4'h1,
    PW_SUSPEND = 4'h2,
    PW_PDOWN = 4'h4,
    PW_SREF = 4'h8
  } ddfe_pwr_t;

  // Column of transfer idx within a burst of 4 or 8
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                 input logic [2:0] idx,
                                                 input logic bl8,
                                                 input logic intlv);
    logic [2:0] mask;
    logic [2:0] low;
    mask = bl8 ? 3'h7 : 3'h3;
    low = intlv ? (start[2:0] ^ idx) : 3'(start[2:0] + idx);
    return {start[COL_W-1:3], (start[2:0] & ~mask) | (low & mask)};
  endfunction

endpackage

// ### ddfe_burst_if.sv
`timescale 1ns/1ps
interface ddfe_burst_if;
  import ddfe_pkg::*;
  logic start;
  logic [COL_W-1:0] start_col;
  logic bl8;
  logic intlv;
  logic run;
  logic busy;
  logic beat;
  logic last;
  logic [COL_W-1:0] col_rise;
  logic [COL_W-1:0] col_fall;
  modport ctl (output start, start_col, bl8, intlv, run,
               input busy, beat, last, col_rise, col_fall);
  modport eng (input start, start_col, bl8, intlv, run,
               output busy, beat, last, col_rise, col_fall);
endinterface

// ### ddfe_burst.sv
`timescale 1ns/1ps
module ddfe_burst
  import ddfe_pkg::*;
(
  // Link clock and reset
  input wire logic i_ck,
  input wire logic i_rst,
  // Burst control
  ddfe_burst_if.eng bus
);

  logic [2:0] idx_ff;
  logic [COL_W-1:0] base_ff;
  logic bl8_ff;
  logic intlv_ff;
  logic busy_ff;
  logic beat_ff;
  logic last_ff;
  logic [COL_W-1:0] col_rise_ff;
  logic [COL_W-1:0] col_fall_ff;
  logic at_last;

  assign at_last = (idx_ff == (bl8_ff ? LAST_IDX_BL8 : LAST_IDX_BL4));

  // ---------------------------------------------------------------------------
  // Column sequencer, two transfers per clock
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ck or posedge i_rst) begin
    if (i_rst) begin
      idx_ff <= 3'h0;
      base_ff <= '0;
      bl8_ff <= 1'b0;
      intlv_ff <= 1'b0;
      busy_ff <= 1'b0;
      beat_ff <= 1'b0;
      last_ff <= 1'b0;
      col_rise_ff <= '0;
      col_fall_ff <= '0;
    end else if (bus.run) begin
      if (bus.start) begin
        base_ff <= bus.start_col;
        bl8_ff <= bus.bl8;
        intlv_ff <= bus.intlv;
        idx_ff <= 3'h2;
        busy_ff <= 1'b1;
        beat_ff <= 1'b1;
        last_ff <= 1'b0;
        col_rise_ff <= burst_col(bus.start_col, 3'h0, bus.bl8, bus.intlv);
        col_fall_ff <= burst_col(bus.start_col, 3'h1, bus.bl8, bus.intlv);
      end else if (busy_ff) begin
        col_rise_ff <= burst_col(base_ff, idx_ff, bl8_ff, intlv_ff);
        col_fall_ff <= burst_col(base_ff, 3'(idx_ff + 3'h1), bl8_ff, intlv_ff);
        idx_ff <= 3'(idx_ff + 3'h2);
        beat_ff <= 1'b1;
        last_ff <= at_last;
        busy_ff <= !at_last;
      end else begin
        beat_ff <= 1'b0;
        last_ff <= 1'b0;
      end
    end
  end

  assign bus.busy = busy_ff;
  assign bus.beat = beat_ff;
  assign bus.last = last_ff;
  assign bus.col_rise = col_rise_ff;
  assign bus.col_fall = col_fall_ff;

endmodule // ddfe_burst

// ### ddfe_top.sv
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module ddfe_top
  import ddfe_pkg::*;
#(
  parameter int ROW_W = ROW_W_DOC,
  parameter int AXI_AW = 8
) (
  // System clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST,
  // Register bus, AXI4-Lite
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [AXI_AW-1:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [AXI_AW-1:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // Memory link, clocked by the controller
  input wire logic I_LINK_CK,
  input wire logic I_CKE,
  input wire logic I_CS_N,
  input wire logic I_RAS_N,
  input wire logic I_CAS_N,
  input wire logic I_WE_N,
  input wire logic [BA_W-1:0] I_BA,
  input wire logic [ROW_W-1:0] I_ADDR,
  input wire logic [DQ_W-1:0] I_DQ,
  // Read data
  output logic [DQ_W-1:0] O_DQ_RISE,
  output logic [DQ_W-1:0] O_DQ_FALL,
  output logic O_DQ_OE
);

  localparam int MEM_AW = BA_W + ROW_W + COL_W;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  ddfe_burst_if bif ();

  logic lrst_meta_ff;
  logic lrst_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [CTRL_W-1:0] cfg_meta_ff;
  logic [CTRL_W-1:0] cfg_ff;
  ddfe_pwr_t pwr_ff;
  ddfe_pwr_t nxt_pwr;
  logic run;
  logic cmd_ok;
  logic [2:0] cmd;
  logic [LAT_W-1:0] lat_total;
  logic [LAT_W-1:0] al_cyc;
  logic [NUM_BANKS-1:0] open_ff;
  logic [ROW_W-1:0] row_ff [NUM_BANKS];
  logic pend_ff;
  logic pend_wr_ff;
  logic pend_ap_ff;
  logic [BA_W-1:0] pend_ba_ff;
  logic [COL_W-1:0] pend_col_ff;
  logic [LAT_W-1:0] lat_ff;
  logic start_ff;
  logic act_wr_ff;
  logic act_ap_ff;
  logic [BA_W-1:0] act_ba_ff;
  logic ref_tgl_ff;
  logic beat_hit;
  logic [DQ_W-1:0] mem [2**MEM_AW];
  logic wrf_pend_ff;
  logic [MEM_AW-1:0] wrf_addr_ff;
  logic [DQ_W-1:0] fall_in_ff;
  logic [DQ_W-1:0] dq_rise_ff;
  logic [DQ_W-1:0] dq_fall_next_ff;
  logic [DQ_W-1:0] dq_fall_ff;
  logic dq_oe_ff;
  logic [STAT_W-1:0] stat_link;
  logic [STAT_W-1:0] stat_meta_ff;
  logic [STAT_W-1:0] stat_ff;
  logic [2:0] ref_sync_ff;
  logic [31:0] refcnt_ff;
  logic awready_ff;
  logic wready_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [AXI_AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  function automatic logic [MEM_AW-1:0] mem_idx(input logic [BA_W-1:0] ba,
                                                input logic [ROW_W-1:0] row,
                                                input logic [COL_W-1:0] col);
    return {ba, row, col};
  endfunction

  // ---------------------------------------------------------------------------
  // Link reset and configuration crossing
  // ---------------------------------------------------------------------------
  always_ff @(posedge I_LINK_CK or posedge I_RST) begin
    if (I_RST) begin
      lrst_meta_ff <= 1'b1;
      lrst_ff <= 1'b1;
    end else begin
      lrst_meta_ff <= 1'b0;
      lrst_ff <= lrst_meta_ff;
    end
  end

  // Per-bit sync: software changes settings only while the link is idle
  always_ff @(posedge I_LINK_CK or posedge lrst_ff) begin
    if (lrst_ff) begin
      cfg_meta_ff <= {INTLV_RST, BL8_RST, 2'h0, AL_RST, CL_RST};
      cfg_ff <= {INTLV_RST, BL8_RST, 2'h0, AL_RST, CL_RST};
    end else begin
      cfg_meta_ff <= ctrl_ff;
      cfg_ff <= cfg_meta_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // Clock gate and power state
  // ---------------------------------------------------------------------------
  assign run = (pwr_ff == PW_ACTIVE);
  assign cmd = {I_RAS_N, I_CAS_N, I_WE_N};
  assign cmd_ok = run && I_CKE && !I_CS_N;

  always_comb begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      PW_ACTIVE: begin
        if (!I_CKE) begin
          if (!I_CS_N && cmd == CMD_REF) begin
            nxt_pwr = PW_SREF;
          end else if (open_ff == '0 && !pend_ff && !bif.busy) begin
            nxt_pwr = PW_PDOWN;
          end else begin
            nxt_pwr = PW_SUSPEND;
          end
        end
      end
      PW_SUSPEND, PW_PDOWN, PW_SREF: begin
        if (I_CKE) begin
          nxt_pwr = PW_ACTIVE;
        end
      end
      default: nxt_pwr = PW_ACTIVE;
    endcase
  end

  // Only the rising edge samples the command pins
  always_ff @(posedge I_LINK_CK or posedge lrst_ff) begin
    if (lrst_ff) begin
      pwr_ff <= PW_ACTIVE;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  // ---------------------------------------------------------------------------
  // Bank state
  // ---------------------------------------------------------------------------
  assign beat_hit = run && bif.beat;

  always_ff @(posedge I_LINK_CK or posedge lrst_ff) begin
    if (lrst_ff) begin
      open_ff <= '0;
      for (int b = 0; b < NUM_BANKS; b++) begin
        row_ff[b] <= '0;
      end
    end else begin
      if (beat_hit && bif.last && act_ap_ff) begin
        open_ff[act_ba_ff] <= 1'b0;
      end
      if (cmd_ok && cmd == CMD_ACT) begin
        open_ff[I_BA] <= 1'b1;
        row_ff[I_BA] <= I_ADDR;
      end
      if (cmd_ok && cmd == CMD_PRE) begin
        if (I_ADDR[AUTO_CLOSE_BIT]) begin
          open_ff <= '0;
        end else begin
          open_ff[I_BA] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Posted column commands
  // ---------------------------------------------------------------------------
  always_comb begin
    unique case (cfg_ff[AL_LSB +: AL_W])
      AL_CL_M1: al_cyc = LAT_W'(cfg_ff[CL_LSB +: CL_W] - 4'h1);
      AL_CL_M2: al_cyc = LAT_W'(cfg_ff[CL_LSB +: CL_W] - 4'h2);
      default: al_cyc = '0;
    endcase
    lat_total = LAT_W'(al_cyc + LAT_W'(cfg_ff[CL_LSB +: CL_W]));
  end

  // One posted command at a time; a second while one waits is dropped
  always_ff @(posedge I_LINK_CK or posedge lrst_ff) begin
    if (lrst_ff) begin
      pend_ff <= 1'b0;
      pend_wr_ff <= 1'b0;
      pend_ap_ff <= 1'b0;
      pend_ba_ff <= '0;
      pend_col_ff <= '0;
      lat_ff <= '0;
      start_ff <= 1'b0;
      act_wr_ff <= 1'b0;
      act_ap_ff <= 1'b0;
      act_ba_ff <= '0;
    end else if (run) begin
      start_ff <= 1'b0;
      if (pend_ff) begin
        if (lat_ff < LAT_W'(2)) begin
          pend_ff <= 1'b0;
          start_ff <= 1'b1;
          act_wr_ff <= pend_wr_ff;
          act_ap_ff <= pend_ap_ff;
          act_ba_ff <= pend_ba_ff;
        end else begin
          lat_ff <= LAT_W'(lat_ff - LAT_W'(1));
        end
      end else if (cmd_ok && (cmd == CMD_RD || cmd == CMD_WR)) begin
        pend_ff <= 1'b1;
        pend_wr_ff <= (cmd == CMD_WR);
        pend_ap_ff <= I_ADDR[AUTO_CLOSE_BIT];
        pend_ba_ff <= I_BA;
        pend_col_ff <= I_ADDR[COL_W-1:0];
        lat_ff <= lat_total;
      end
    end
  end

  assign bif.start = start_ff;
  assign bif.start_col = pend_col_ff;
  assign bif.bl8 = cfg_ff[BL8_BIT];
  assign bif.intlv = cfg_ff[INTLV_BIT];
  assign bif.run = run;

  ddfe_burst u_burst (
    .i_ck (I_LINK_CK),
    .i_rst (lrst_ff),
    .bus (bif.eng)
  );

  // Refresh events leave as a toggle
  always_ff @(posedge I_LINK_CK or posedge lrst_ff) begin
    if (lrst_ff) begin
      ref_tgl_ff <= 1'b0;
    end else if (cmd_ok && cmd == CMD_REF) begin
      ref_tgl_ff <= !ref_tgl_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // Storage and data path
  // ---------------------------------------------------------------------------
  always_ff @(posedge I_LINK_CK) begin
    if (beat_hit && act_wr_ff) begin
      mem[mem_idx(act_ba_ff, row_ff[act_ba_ff], bif.col_rise)] <= I_DQ;
    end
    if (wrf_pend_ff) begin
      mem[wrf_addr_ff] <= fall_in_ff;
    end
  end

  // Falling-half write byte waits one edge before it is stored
  always_ff @(posedge I_LINK_CK or posedge lrst_ff) begin
    if (lrst_ff) begin
      wrf_pend_ff <= 1'b0;
      wrf_addr_ff <= '0;
    end else begin
      wrf_pend_ff <= beat_hit && act_wr_ff;
      wrf_addr_ff <= mem_idx(act_ba_ff, row_ff[act_ba_ff], bif.col_fall);
    end
  end

  always_ff @(negedge I_LINK_CK or posedge lrst_ff) begin
    if (lrst_ff) begin
      fall_in_ff <= '0;
    end else if (wrf_pend_ff) begin
      fall_in_ff <= I_DQ;
    end
  end

  always_ff @(posedge I_LINK_CK or posedge lrst_ff) begin
    if (lrst_ff) begin
      dq_rise_ff <= '0;
      dq_fall_next_ff <= '0;
      dq_oe_ff <= 1'b0;
    end else if (run) begin
      dq_oe_ff <= bif.beat && !act_wr_ff;
      if (bif.beat && !act_wr_ff) begin
        dq_rise_ff <= mem[mem_idx(act_ba_ff, row_ff[act_ba_ff], bif.col_rise)];
        dq_fall_next_ff <= mem[mem_idx(act_ba_ff, row_ff[act_ba_ff], bif.col_fall)];
      end
    end
  end

  // Second half of each beat leaves on the falling edge
  always_ff @(negedge I_LINK_CK or posedge lrst_ff) begin
    if (lrst_ff) begin
      dq_fall_ff <= '0;
    end else begin
      dq_fall_ff <= dq_fall_next_ff;
    end
  end

  assign O_DQ_RISE = dq_rise_ff;
  assign O_DQ_FALL = dq_fall_ff;
  assign O_DQ_OE = dq_oe_ff;

  // ---------------------------------------------------------------------------
  // Status crossing into the system clock
  // ---------------------------------------------------------------------------
  assign stat_link = {bif.busy, open_ff, pwr_ff};

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      stat_meta_ff <= {1'b0, {NUM_BANKS{1'b0}}, PW_ACTIVE};
      stat_ff <= {1'b0, {NUM_BANKS{1'b0}}, PW_ACTIVE};
      ref_sync_ff <= 3'h0;
      refcnt_ff <= 32'h0;
    end else begin
      stat_meta_ff <= stat_link;
      stat_ff <= stat_meta_ff;
      ref_sync_ff <= {ref_sync_ff[1:0], ref_tgl_ff};
      if (ref_sync_ff[2] != ref_sync_ff[1]) begin
        refcnt_ff <= 32'(refcnt_ff + 32'h1);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      ctrl_ff <= {INTLV_RST, BL8_RST, 2'h0, AL_RST, CL_RST};
    end else begin
      if (I_AWVALID && awready_ff) begin
        awready_ff <= 1'b0;
        aw_held_ff <= 1'b1;
        awaddr_ff <= I_AWADDR;
      end
      if (I_WVALID && wready_ff) begin
        wready_ff <= 1'b0;
        w_held_ff <= 1'b1;
        wdata_ff <= I_WDATA;
        wstrb_ff <= I_WSTRB;
      end
      if (aw_held_ff && w_held_ff && !bvalid_ff) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        if (awaddr_ff[7:0] == CTRL_OFS) begin
          bresp_ff <= RESP_OKAY;
          if (wstrb_ff[0]) begin
            ctrl_ff[7:0] <= wdata_ff[7:0];
          end
          if (wstrb_ff[1]) begin
            ctrl_ff[CTRL_W-1:8] <= wdata_ff[CTRL_W-1:8];
          end
        end else if (awaddr_ff[7:0] == STATUS_OFS || awaddr_ff[7:0] == REFCNT_OFS) begin
          bresp_ff <= RESP_OKAY;
        end else begin
          bresp_ff <= RESP_SLVERR;
        end
      end
      if (bvalid_ff && I_BREADY) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
    end else begin
      if (I_ARVALID && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rresp_ff <= RESP_OKAY;
        rdata_ff <= 32'h0;
        unique case (I_ARADDR[7:0])
          CTRL_OFS: rdata_ff <= {22'h0, ctrl_ff};
          STATUS_OFS: begin
            rdata_ff[PWR_LSB +: 4] <= stat_ff[3:0];
            rdata_ff[OPEN_LSB +: NUM_BANKS] <= stat_ff[11:4];
            rdata_ff[BUSY_BIT] <= stat_ff[12];
          end
          REFCNT_OFS: rdata_ff <= refcnt_ff;
          default: rresp_ff <= RESP_SLVERR;
        endcase
      end
      if (rvalid_ff && I_RREADY) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  assign O_AWREADY = awready_ff;
  assign O_WREADY = wready_ff;
  assign O_BVALID = bvalid_ff;
  assign O_BRESP = bresp_ff;
  assign O_ARREADY = arready_ff;
  assign O_RVALID = rvalid_ff;
  assign O_RDATA = rdata_ff;
  assign O_RRESP = rresp_ff;

endmodule // ddfe_top

// ### ddfe_top_monitor.sv
`timescale 1ns/1ps
module ddfe_top_monitor
  import ddfe_pkg::*;
(
  // Clocks and reset
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_LINK_CK,
  // Register bus
  input wire logic O_AWREADY,
  input wire logic O_WREADY,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [31:0] O_RDATA,
  // Link
  input wire logic I_CKE,
  input wire logic [DQ_W-1:0] O_DQ_RISE,
  input wire logic O_DQ_OE
);
  property p_bh;
    @(posedge I_MCLK) disable iff (I_RST) O_BVALID && !I_BREADY |=> O_BVALID;
  endproperty
  a_bh: assert property (p_bh) else $error("bvalid dropped");
  property p_bw;
    @(posedge I_MCLK) disable iff (I_RST) O_BVALID |-> !O_AWREADY && !O_WREADY;
  endproperty
  a_bw: assert property (p_bw) else $error("ready during response");
  property p_bd;
    @(posedge I_MCLK) disable iff (I_RST) O_BVALID && I_BREADY |=> !O_BVALID && O_AWREADY;
  endproperty
  a_bd: assert property (p_bd) else $error("write not closed");
  property p_ra;
    @(posedge I_MCLK) disable iff (I_RST) I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY;
  endproperty
  a_ra: assert property (p_ra) else $error("read answer late");
  property p_rh;
    @(posedge I_MCLK) disable iff (I_RST) O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
  endproperty
  a_rh: assert property (p_rh) else $error("read data not held");
  property p_rd;
    @(posedge I_MCLK) disable iff (I_RST) O_RVALID && I_RREADY |=> !O_RVALID && O_ARREADY;
  endproperty
  a_rd: assert property (p_rd) else $error("read not closed");
  // Gate low on two edges: rise data and enable may not move on the second
  property p_fz;
    @(posedge I_LINK_CK) disable iff (I_RST)
      !I_CKE ##1 !I_CKE |=> $stable(O_DQ_RISE) && $stable(O_DQ_OE);
  endproperty
  a_fz: assert property (p_fz) else $error("outputs moved while gated");
  property p_bt;
    @(posedge I_LINK_CK) disable iff (I_RST) $rose(O_DQ_OE) |=> O_DQ_OE;
  endproperty
  a_bt: assert property (p_bt) else $error("burst shorter than two beats");
  c_rd: cover property (@(posedge I_MCLK) I_ARVALID && O_ARREADY);
  c_oe: cover property (@(posedge I_LINK_CK) $rose(O_DQ_OE));
  c_gt: cover property (@(posedge I_LINK_CK) $fell(I_CKE));
endmodule // ddfe_top_monitor

bind ddfe_top ddfe_top_monitor u_mon (.*);

// ### ddfe_ctrl_model.sv
`timescale 1ns/1ps
module ddfe_ctrl_model
  import ddfe_pkg::*;
(
  // Link clock and gate
  output logic o_ck,
  output logic o_cke,
  // Command
  output logic o_cs_n,
  output logic [2:0] o_cmd,
  output logic [2:0] o_ba,
  output logic [10:0] o_addr,
  // Write data
  output logic [7:0] o_dq
);
  initial begin
    o_ck = 1'b0;
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    o_cmd = 3'h7;
    o_ba = 3'h0;
    o_addr = 11'h0;
    o_dq = 8'h0;
  end
  // Free running: the gate pin, not the clock, stops the memory
  always #16 o_ck = ~o_ck;
  task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [10:0] a,
                     input logic cs, input logic ce);
    @(posedge o_ck);
    o_cke <= ce;
    o_cs_n <= cs;
    o_cmd <= c;
    o_ba <= b;
    o_addr <= a;
    @(posedge o_ck);
    o_cs_n <= 1'b1;
    o_ba <= ~b;
    o_addr <= ~a;
  endtask
  // Rise byte set before its rising edge, fall byte before its falling edge
  task automatic wdata(input int l, input logic [7:0] q[$]);
    repeat (l + 1) @(posedge o_ck);
    foreach (q[i]) begin
      if (i % 2 == 0) @(negedge o_ck);
      else @(posedge o_ck);
      o_dq <= q[i];
    end
    @(negedge o_ck);
    o_dq <= ~o_dq;
  endtask
  // Average refresh spacing; 8192 at the cool spacing fill 64 ms
  localparam realtime REF_GAP_COOL = 7.8us;
  // Hot case above 85 C halves the spacing
  localparam realtime REF_GAP_HOT = 3.9us;
  task automatic refresh(input logic hot);
    cmd(CMD_REF, 3'h0, 11'h0, 1'b0, 1'b1);
    if (hot) #(REF_GAP_HOT);
    else #(REF_GAP_COOL);
  endtask
endmodule // ddfe_ctrl_model

// ### ddfe_top_test.sv
`timescale 1ns/1ps
module ddfe_top_test;
  import ddfe_pkg::*;
  logic mclk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdd;
  logic [1:0] rsp;
  wire awr, wrr, bv, arr, rv, lk, cke, csn, oe;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [2:0] cm, ba;
  wire [10:0] ad;
  wire [7:0] dq, dr, df;
  int n_fail = 0, n_checks = 0;
  always #5 mclk = ~mclk;
  ddfe_ctrl_model m (.o_ck(lk), .o_cke(cke), .o_cs_n(csn), .o_cmd(cm), .o_ba(ba),
    .o_addr(ad), .o_dq(dq));
  ddfe_top #(.ROW_W(11)) u_dut (.I_MCLK(mclk), .I_RST(rst), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrr), .I_WDATA(wd),
    .I_WSTRB(4'hF), .O_BVALID(bv), .I_BREADY(bry), .O_BRESP(br), .I_ARVALID(arv),
    .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rry), .O_RDATA(rdat),
    .O_RRESP(rr), .I_LINK_CK(lk), .I_CKE(cke), .I_CS_N(csn), .I_RAS_N(cm[2]),
    .I_CAS_N(cm[1]), .I_WE_N(cm[0]), .I_BA(ba), .I_ADDR(ad), .I_DQ(dq),
    .O_DQ_RISE(dr), .O_DQ_FALL(df), .O_DQ_OE(oe));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tmo(input int i);
    if (i == 99) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    {awv, wv, bry} <= 3'h7;
    awa <= a;
    wd <= d;
    for (i = 0; i < 99; i++) begin
      @(posedge mclk);
      if (awr) awv <= 1'b0;
      if (wrr) wv <= 1'b0;
      if (bv) break;
    end
    bry <= 1'b0;
    rsp = br;
    tmo(i);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int i;
    @(posedge mclk);
    {arv, rry} <= 2'h3;
    ara <= a;
    for (i = 0; i < 99; i++) begin
      @(posedge mclk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rry <= 1'b0;
    rdd = rdat;
    rsp = rr;
    tmo(i);
  endtask
  function automatic logic [7:0] pat(input logic [2:0] b, input logic [2:0] c);
    return {b, 2'h0, c};
  endfunction
  function automatic logic [2:0] ord(input logic [2:0] s, input int i, input logic b8, il);
    logic [2:0] mk, lo;
    mk = b8 ? 3'h7 : 3'h3;
    lo = il ? s ^ 3'(i) : s + 3'(i);
    return (s & ~mk) | (lo & mk);
  endfunction
  task automatic wr8(input logic [2:0] b);
    logic [7:0] q[$];
    for (int i = 0; i < 8; i++) q.push_back(pat(b, 3'(i)));
    m.cmd(CMD_WR, b, 11'h0, 0, 1);
    m.wdata(5, q);
  endtask
  task automatic rd(input logic [2:0] b, s, input int l, input logic b8, il, ap);
    m.cmd(CMD_RD, b, {ap, 7'h0, s}, 0, 1);
    // Same variable as the command edge, so that edge is not counted twice
    repeat (l + 1) @(posedge m.o_ck);
    #1 chk("oe early", 0, oe);
    for (int k = 0; k < (b8 ? 4 : 2); k++) begin
      @(posedge lk);
      #1 chk("oe", 1, oe);
      chk("rise", pat(b, ord(s, 2 * k, b8, il)), dr);
      @(negedge lk);
      #1 chk("fall", pat(b, ord(s, 2 * k + 1, b8, il)), df);
    end
    @(posedge lk);
    #1 chk("oe end", 0, oe);
  endtask
  task automatic cfg(input logic [31:0] d);
    axi_wr(CTRL_OFS, d);
    repeat (4) @(posedge lk);
  endtask
  task automatic st(input logic [31:0] e);
    repeat (8) @(posedge mclk);
    axi_rd(STATUS_OFS);
    chk("status", e, rdd & 32'hFFFF);
  endtask
  task automatic t_regs;
    axi_rd(CTRL_OFS);
    chk("ctrl", 32'h105, rdd);
    axi_rd(8'h0C);
    chk("unmapped rd", RESP_SLVERR, rsp);
    axi_wr(STATUS_OFS, 32'hFF);
    chk("ro wr", RESP_OKAY, rsp);
    axi_wr(8'h10, 32'h0);
    chk("unmapped wr", RESP_SLVERR, rsp);
    st(32'h1);
  endtask
  task automatic t_data;
    m.cmd(CMD_ACT, 3'h1, 11'h0, 0, 1);
    m.cmd(CMD_ACT, 3'h3, 11'h0, 0, 1);
    wr8(3'h1);
    wr8(3'h3);
    rd(3'h1, 3'h5, 5, 1, 0, 0);
    rd(3'h3, 3'h2, 5, 1, 0, 0);
    cfg(32'h216);
    rd(3'h1, 3'h6, 11, 0, 1, 1);
    cfg(32'h126);
    rd(3'h3, 3'h3, 10, 1, 0, 0);
    st(32'h0801);
  endtask
  task automatic t_cs;
    logic [31:0] n;
    n = 0;
    m.cmd(CMD_RD, 3'h3, 11'h0, 1, 1);
    repeat (20) begin
      @(posedge lk);
      #1 n = n + oe;
    end
    chk("cs high", 0, n);
  endtask
  // Gate low on two edges while a read waits: data comes two cycles later
  task automatic t_gate;
    fork
      rd(3'h3, 3'h1, 12, 1, 0, 0);
      begin
        repeat (2) @(posedge lk);
        m.cmd(3'h7, 3'h0, 11'h0, 1, 0);
        m.cmd(3'h7, 3'h0, 11'h0, 1, 1);
      end
    join
  endtask
  task automatic t_pwr;
    m.cmd(3'h7, 3'h0, 11'h0, 1, 0);
    st(32'h0802);
    m.cmd(3'h7, 3'h0, 11'h0, 1, 1);
    m.cmd(CMD_PRE, 3'h0, 11'h400, 0, 1);
    m.cmd(3'h7, 3'h0, 11'h0, 1, 0);
    st(32'h4);
    m.cmd(3'h7, 3'h0, 11'h0, 1, 1);
    m.refresh(1'b0);
    m.refresh(1'b1);
    repeat (8) @(posedge mclk);
    axi_rd(REFCNT_OFS);
    chk("refcnt", 2, rdd);
    m.cmd(CMD_REF, 3'h0, 11'h0, 0, 0);
    st(32'h8);
    m.cmd(3'h7, 3'h0, 11'h0, 1, 1);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge lk);
    t_regs();
    t_data();
    t_gate();
    t_cs();
    t_pwr();
    give_verdict();
  end
endmodule // ddfe_top_test
